// [verilog/motion_pkg.sv]
// Constants shared by the drive end and the motion master end.
// Assumes a single 125 MHz clock for both ends.
package motion_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int US_TICK_TIME_US = 1;
  localparam logic [7:0] US_TICK_CYCLES = 8'(CLK_MHZ * US_TICK_TIME_US);
  localparam logic [31:0] CYCLE_THRESH_US = 32'h0000_09c4;
  // ----------------------------------------
  // Object dictionary indices and sub-indices
  // ----------------------------------------
  localparam logic [15:0] OBJ_CYCLE_PERIOD = 16'h1006;
  localparam logic [15:0] OBJ_MODE_SELECT = 16'h6060;
  localparam logic [15:0] OBJ_SUBMODE = 16'h60c0;
  localparam logic [15:0] OBJ_DATA_RECORD = 16'h60c1;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_POS = 8'h01;
  localparam logic [7:0] SUB_VEL_CNT = 8'h02;
  localparam logic [7:0] SUB_VEL_RPM = 8'h03;
  localparam logic [31:0] RECORD_ENTRIES = 32'h0000_0003;
  localparam logic [15:0] MODE_INTERP = 16'h00ca;
  localparam logic [15:0] SUBMODE_LINEAR = 16'h0000;
  localparam logic [15:0] SUBMODE_CUBIC_PV = 16'hffff;
  localparam logic [15:0] SUBMODE_CUBIC_P = 16'hfffe;
  localparam logic [15:0] SUBMODE_RESET = 16'h0000;
  localparam logic [31:0] CYCLE_PERIOD_RESET = 32'h0000_0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // ----------------------------------------
  // Statusword and fault reaction
  // ----------------------------------------
  localparam int BIT_TARGET_REACHED = 10;
  localparam int BIT_FOLLOW_ERR = 13;
  localparam int BIT_FOLLOW_ERR_IP = 14;
  localparam logic [15:0] EMCY_FOLLOW_ERR = 16'hff11;
  localparam logic [1:0] REACT_CODE_MAX = 2'h2;
  localparam logic [1:0] REACT_CODE_DEFAULT = 2'h0;
  // ----------------------------------------
  // Master register map (APB byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_OBJ_SEL = 8'h00;
  localparam logic [7:0] REG_OBJ_WDATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_OBJ_RDATA = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_EMCY_CODE = 8'h1c;
  localparam logic [7:0] REG_EMCY_DATA = 8'h20;
  localparam int CMD_WRITE = 0;
  localparam int CMD_SYNC = 1;
  localparam int CMD_READ = 2;
  localparam int IRQ_EMCY = 0;
  localparam int IRQ_REACHED = 1;
  localparam int IRQ_FOLLOW = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_RDATA = 4;
  localparam int IRQ_BITS = 5;
endpackage : motion_pkg

// [verilog/motion_link_if.sv]
// Link between the motion master and the drive.
// Both ends run on the same ref_clk; the bench joins them.
`timescale 1ns/10ps
interface motion_link_if (
  input wire logic ref_clk
);
  logic obj_wr;
  logic obj_rd;
  logic [15:0] obj_index;
  logic [7:0] obj_sub;
  logic [31:0] obj_wdata;
  logic sync;
  logic obj_rvalid;
  logic [31:0] obj_rdata;
  logic [15:0] statusword;
  logic emcy_valid;
  logic [15:0] emcy_code;
  logic [31:0] emcy_data;
  modport master (
    output obj_wr, obj_rd, obj_index, obj_sub, obj_wdata, sync,
    input obj_rvalid, obj_rdata, statusword, emcy_valid, emcy_code, emcy_data
  );
  modport drive (
    input obj_wr, obj_rd, obj_index, obj_sub, obj_wdata, sync,
    output obj_rvalid, obj_rdata, statusword, emcy_valid, emcy_code, emcy_data
  );
endinterface : motion_link_if

// [verilog/motion_drive.sv]
// Drive end: position windows, fault reaction and interpolated setpoints.
// Assumes all user-side inputs come from logic on ref_clk.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module motion_drive (
  input wire logic ref_clk,
  input wire logic resetn,
  motion_link_if.drive link,
  input wire logic [31:0] actual_pos,
  input wire logic [31:0] target_pos,
  input wire logic [31:0] pos_window,
  input wire logic [31:0] pos_window_cycles,
  input wire logic [31:0] ferr_window,
  input wire logic [31:0] ferr_timeout_cycles,
  input wire logic following_fault_reaction_enable,
  input wire logic [1:0] fault_reaction_code,
  input wire logic [31:0] emergency_user_data_pair,
  input wire logic ffw_from_position_enable,
  input wire logic [2:0] pdo_map,
  input wire logic motor_stopped,
  output logic [31:0] loop_target,
  output logic [31:0] velocity_ref,
  output logic [31:0] velocity_ffw,
  output logic position_loop_on,
  output logic native_units,
  output logic [15:0] interp_mode,
  output logic stop_req,
  output logic [1:0] stop_code,
  output logic motor_disable
);
  typedef enum logic [1:0] {F_IDLE = 2'b00, F_STOP = 2'b01, F_DISABLED = 2'b10} fault_state_t;
  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? (32'h0 - d) : d;
  endfunction : abs_diff

  // ----------------------------------------
  // Objects and setpoint pipeline
  // ----------------------------------------
  logic [15:0] mode_reg, mode_next, submode_reg, submode_next;
  logic [31:0] period_reg, period_next, vel_cnt_reg, vel_cnt_next, vel_rpm_reg, vel_rpm_next;
  logic [31:0] buf_reg [2], buf_next [2];
  logic [31:0] us_cnt_reg, us_cnt_next, prev_ref_reg, prev_ref_next, target_reg, target_next;
  logic [31:0] stage1_reg, stage1_next, stage2_reg, stage2_next, rdata_reg, rdata_next;
  logic [31:0] vref_reg, vref_next, ffw_reg, ffw_next;
  logic ptr_reg, ptr_next, new_rec_reg, new_rec_next, in_cycle_reg, in_cycle_next;
  logic stage1_v_reg, stage1_v_next, stage2_v_reg, stage2_v_next, rvalid_reg, rvalid_next;
  logic [7:0] div_reg, div_next;
  logic ip, short_cycle, us_tick, cycle_end, pos_mapped;
  logic [7:0] last_sub;
  logic [31:0] latest;
  always_comb begin
    ip = (mode_reg == motion_pkg::MODE_INTERP);
    short_cycle = (period_reg < motion_pkg::CYCLE_THRESH_US);
    pos_mapped = pdo_map[0];
    last_sub = pdo_map[2] ? motion_pkg::SUB_VEL_RPM :
               (pdo_map[1] ? motion_pkg::SUB_VEL_CNT : motion_pkg::SUB_POS);
    latest = buf_reg[~ptr_reg];
    us_tick = (div_reg == motion_pkg::US_TICK_CYCLES - 8'h01);
    // A sync arriving early also closes the running cycle
    cycle_end = in_cycle_reg && (link.sync || (us_tick && (us_cnt_reg + 32'h1 >= period_reg)));
    {mode_next, period_next, submode_next} = {mode_reg, period_reg, submode_reg};
    buf_next = buf_reg;
    {ptr_next, new_rec_next, in_cycle_next} = {ptr_reg, new_rec_reg, in_cycle_reg};
    {vel_cnt_next, vel_rpm_next, prev_ref_next} = {vel_cnt_reg, vel_rpm_reg, prev_ref_reg};
    div_next = us_tick ? 8'h00 : div_reg + 8'h01;
    us_cnt_next = us_tick ? us_cnt_reg + 32'h1 : us_cnt_reg;
    {stage1_next, stage2_next, stage1_v_next, stage2_v_next} =
      {stage1_reg, stage2_reg, stage1_v_reg, stage2_v_reg};
    {target_next, vref_next, ffw_next, rdata_next} = {target_reg, vref_reg, ffw_reg, rdata_reg};
    rvalid_next = link.obj_rd;
    if (cycle_end && ip && !short_cycle) begin
      if (submode_reg == motion_pkg::SUBMODE_CUBIC_P) begin
        if (stage2_v_reg) begin
          target_next = stage2_reg;
        end
        stage2_next = stage1_reg;
        stage2_v_next = stage1_v_reg;
      end else if (stage1_v_reg) begin
        target_next = stage1_reg;
      end
      stage1_v_next = 1'b0;
    end
    if (link.sync) begin
      div_next = 8'h00;
      us_cnt_next = 32'h0;
      in_cycle_next = 1'b1;
    end
    if (link.sync && ip) begin
      new_rec_next = 1'b0;
      if (!pos_mapped) begin
        vref_next = pdo_map[2] ? vel_rpm_reg : vel_cnt_reg;
      end else if (short_cycle) begin
        target_next = latest;
      end else if (new_rec_reg) begin
        stage1_next = latest;
        stage1_v_next = 1'b1;
      end
      prev_ref_next = latest;
      if (short_cycle && ffw_from_position_enable) begin
        ffw_next = latest - prev_ref_reg;
      end else if (pdo_map[2]) begin
        ffw_next = vel_rpm_reg;
      end else begin
        ffw_next = 32'h0;
      end
    end
    if (link.obj_wr) begin
      case (link.obj_index)
        motion_pkg::OBJ_MODE_SELECT: mode_next = link.obj_wdata[15:0];
        motion_pkg::OBJ_CYCLE_PERIOD: period_next = link.obj_wdata;
        motion_pkg::OBJ_SUBMODE: begin
          // Reserved positive codes are ignored
          if (link.obj_wdata[15:0] == motion_pkg::SUBMODE_LINEAR ||
              link.obj_wdata[15:0] == motion_pkg::SUBMODE_CUBIC_PV ||
              link.obj_wdata[15:0] == motion_pkg::SUBMODE_CUBIC_P) begin
            submode_next = link.obj_wdata[15:0];
          end
        end
        motion_pkg::OBJ_DATA_RECORD: begin
          case (link.obj_sub)
            motion_pkg::SUB_POS: buf_next[ptr_reg] = link.obj_wdata;
            motion_pkg::SUB_VEL_CNT: vel_cnt_next = link.obj_wdata;
            motion_pkg::SUB_VEL_RPM: vel_rpm_next = link.obj_wdata;
            default: ;
          endcase
          if (link.obj_sub == last_sub) begin
            ptr_next = ~ptr_reg;
            new_rec_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (link.obj_rd) begin
      case (link.obj_index)
        motion_pkg::OBJ_MODE_SELECT: rdata_next = {16'h0000, mode_reg};
        motion_pkg::OBJ_CYCLE_PERIOD: rdata_next = period_reg;
        motion_pkg::OBJ_SUBMODE: rdata_next = {{16{submode_reg[15]}}, submode_reg};
        motion_pkg::OBJ_DATA_RECORD: begin
          case (link.obj_sub)
            motion_pkg::SUB_COUNT: rdata_next = motion_pkg::RECORD_ENTRIES;
            motion_pkg::SUB_POS: rdata_next = latest;
            motion_pkg::SUB_VEL_CNT: rdata_next = vel_cnt_reg;
            motion_pkg::SUB_VEL_RPM: rdata_next = vel_rpm_reg;
            default: rdata_next = 32'h0;
          endcase
        end
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {mode_reg, period_reg, submode_reg} <=
        {motion_pkg::MODE_RESET, motion_pkg::CYCLE_PERIOD_RESET, motion_pkg::SUBMODE_RESET};
      buf_reg <= '{32'h0, 32'h0};
      {ptr_reg, new_rec_reg, in_cycle_reg, stage1_v_reg, stage2_v_reg, rvalid_reg} <= '0;
      {vel_cnt_reg, vel_rpm_reg, us_cnt_reg, stage1_reg, stage2_reg} <= '0;
      {prev_ref_reg, target_reg, vref_reg, ffw_reg, rdata_reg} <= '0;
      div_reg <= 8'h00;
    end else begin
      {mode_reg, period_reg, submode_reg} <= {mode_next, period_next, submode_next};
      buf_reg <= buf_next;
      {ptr_reg, new_rec_reg, in_cycle_reg} <= {ptr_next, new_rec_next, in_cycle_next};
      {vel_cnt_reg, vel_rpm_reg, prev_ref_reg} <= {vel_cnt_next, vel_rpm_next, prev_ref_next};
      {div_reg, us_cnt_reg, rvalid_reg} <= {div_next, us_cnt_next, rvalid_next};
      {stage1_reg, stage2_reg, stage1_v_reg, stage2_v_reg} <=
        {stage1_next, stage2_next, stage1_v_next, stage2_v_next};
      {target_reg, vref_reg, ffw_reg, rdata_reg} <=
        {target_next, vref_next, ffw_next, rdata_next};
    end
  end

  // ----------------------------------------
  // Windows and fault reaction
  // ----------------------------------------
  logic [31:0] tr_cnt_reg, tr_cnt_next, fe_cnt_reg, fe_cnt_next;
  logic [15:0] sw_reg, sw_next;
  fault_state_t fstate_reg, fstate_next;
  logic [1:0] code_reg, code_next;
  logic ferr_prev_reg, ferr_prev_next, emcy_reg, emcy_next, inside_tr, outside_fe, reached, ferr;
  always_comb begin
    inside_tr = abs_diff(actual_pos, target_pos) <= pos_window;
    outside_fe = abs_diff(actual_pos, target_reg) > ferr_window;
    tr_cnt_next = !inside_tr ? 32'h0 :
                  ((tr_cnt_reg < pos_window_cycles) ? tr_cnt_reg + 32'h1 : tr_cnt_reg);
    fe_cnt_next = !outside_fe ? 32'h0 :
                  ((fe_cnt_reg <= ferr_timeout_cycles) ? fe_cnt_reg + 32'h1 : fe_cnt_reg);
    reached = inside_tr && (tr_cnt_reg >= pos_window_cycles);
    ferr = outside_fe && (fe_cnt_reg > ferr_timeout_cycles);
    sw_next = 16'h0000;
    sw_next[motion_pkg::BIT_TARGET_REACHED] = reached;
    sw_next[motion_pkg::BIT_FOLLOW_ERR] = ferr && !ip;
    sw_next[motion_pkg::BIT_FOLLOW_ERR_IP] = ferr && ip;
    {ferr_prev_next, emcy_next} = {ferr, 1'b0};
    fstate_next = fstate_reg;
    code_next = code_reg;
    case (fstate_reg)
      F_IDLE: begin
        if (following_fault_reaction_enable && ferr && !ferr_prev_reg) begin
          fstate_next = F_STOP;
          // Code 3 is not valid; fall back to the default stop
          code_next = (fault_reaction_code > motion_pkg::REACT_CODE_MAX) ?
                      motion_pkg::REACT_CODE_DEFAULT : fault_reaction_code;
        end
      end
      F_STOP: begin
        if (motor_stopped) begin
          fstate_next = F_DISABLED;
          emcy_next = 1'b1;
        end
      end
      F_DISABLED: begin
        if (!following_fault_reaction_enable) begin
          fstate_next = F_IDLE;
        end
      end
      default: fstate_next = F_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {tr_cnt_reg, fe_cnt_reg, sw_reg, ferr_prev_reg, emcy_reg} <= '0;
      fstate_reg <= F_IDLE;
      code_reg <= motion_pkg::REACT_CODE_DEFAULT;
    end else begin
      {tr_cnt_reg, fe_cnt_reg, sw_reg} <= {tr_cnt_next, fe_cnt_next, sw_next};
      {ferr_prev_reg, emcy_reg, code_reg} <= {ferr_prev_next, emcy_next, code_next};
      fstate_reg <= fstate_next;
    end
  end

  assign link.statusword = sw_reg;
  assign link.emcy_valid = emcy_reg;
  assign link.emcy_code = motion_pkg::EMCY_FOLLOW_ERR;
  assign link.emcy_data = emergency_user_data_pair;
  assign link.obj_rvalid = rvalid_reg;
  assign link.obj_rdata = rdata_reg;
  assign loop_target = target_reg;
  assign velocity_ref = vref_reg;
  assign velocity_ffw = ffw_reg;
  assign position_loop_on = !(ip && !pos_mapped);
  assign native_units = ip;
  assign interp_mode = submode_reg;
  assign stop_req = (fstate_reg == F_STOP);
  assign stop_code = code_reg;
  assign motor_disable = (fstate_reg == F_DISABLED);
endmodule : motion_drive

// [verilog/motion_master.sv]
// Master end: APB register front end that streams objects and syncs.
// Assumes an APB master on ref_clk; the slave answers with no wait state.
`timescale 1ns/10ps
module motion_master (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  motion_link_if.master link
);
  // ----------------------------------------
  // Registers and link drive
  // ----------------------------------------
  logic [23:0] sel_reg, sel_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, prdata_reg, prdata_next;
  logic [31:0] edata_reg, edata_next;
  logic [15:0] ecode_reg, ecode_next, sw_prev_reg, sw_prev_next;
  logic [motion_pkg::IRQ_BITS-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic wr_reg, wr_next, rd_reg, rd_next, sync_reg, sync_next, sync_pend_reg, sync_pend_next;
  logic armed_reg, armed_next;
  logic access, setup, mapped, refuse, record_wr;
  logic [motion_pkg::IRQ_BITS-1:0] ev;

  always_comb begin
    setup = psel && !penable;
    access = psel && penable;
    mapped = (paddr <= motion_pkg::REG_EMCY_DATA) && (paddr[1:0] == 2'b00);
    record_wr = access && pwrite && paddr == motion_pkg::REG_CMD && pwdata[motion_pkg::CMD_WRITE];
    // Records are only streamed once interpolated mode is selected
    refuse = record_wr && sel_reg[15:0] == motion_pkg::OBJ_DATA_RECORD && !armed_reg;
    ev = '0;
    ev[motion_pkg::IRQ_EMCY] = link.emcy_valid;
    ev[motion_pkg::IRQ_REACHED] = link.statusword[motion_pkg::BIT_TARGET_REACHED] &&
                                  !sw_prev_reg[motion_pkg::BIT_TARGET_REACHED];
    ev[motion_pkg::IRQ_FOLLOW] = (link.statusword[motion_pkg::BIT_FOLLOW_ERR] &&
                                  !sw_prev_reg[motion_pkg::BIT_FOLLOW_ERR]) ||
                                 (link.statusword[motion_pkg::BIT_FOLLOW_ERR_IP] &&
                                  !sw_prev_reg[motion_pkg::BIT_FOLLOW_ERR_IP]);
    ev[motion_pkg::IRQ_REFUSED] = refuse;
    ev[motion_pkg::IRQ_RDATA] = link.obj_rvalid;
    sel_next = sel_reg;
    wdata_next = wdata_reg;
    imask_next = imask_reg;
    armed_next = armed_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    sync_next = sync_pend_reg;
    sync_pend_next = 1'b0;
    sw_prev_next = link.statusword;
    rdata_next = link.obj_rvalid ? link.obj_rdata : rdata_reg;
    ecode_next = link.emcy_valid ? link.emcy_code : ecode_reg;
    edata_next = link.emcy_valid ? link.emcy_data : edata_reg;
    // Set wins over the read-clear
    ist_next = ist_reg;
    if (access && !pwrite && paddr == motion_pkg::REG_IRQ_STATUS) begin
      ist_next = '0;
    end
    ist_next = ist_next | ev;
    if (access && pwrite) begin
      case (paddr)
        motion_pkg::REG_OBJ_SEL: sel_next = pwdata[23:0];
        motion_pkg::REG_OBJ_WDATA: wdata_next = pwdata;
        motion_pkg::REG_IRQ_MASK: imask_next = pwdata[motion_pkg::IRQ_BITS-1:0];
        motion_pkg::REG_CMD: begin
          wr_next = pwdata[motion_pkg::CMD_WRITE] && !refuse;
          rd_next = pwdata[motion_pkg::CMD_READ];
          if (pwdata[motion_pkg::CMD_SYNC]) begin
            // Object goes out first, its validating sync one cycle later
            sync_pend_next = pwdata[motion_pkg::CMD_WRITE];
            sync_next = !pwdata[motion_pkg::CMD_WRITE];
          end
          if (pwdata[motion_pkg::CMD_WRITE] && sel_reg[15:0] == motion_pkg::OBJ_MODE_SELECT) begin
            armed_next = (wdata_reg[15:0] == motion_pkg::MODE_INTERP);
          end
        end
        default: ;
      endcase
    end
    prdata_next = prdata_reg;
    if (setup && !pwrite) begin
      case (paddr)
        motion_pkg::REG_OBJ_SEL: prdata_next = {8'h00, sel_reg};
        motion_pkg::REG_OBJ_WDATA: prdata_next = wdata_reg;
        motion_pkg::REG_STATUS: prdata_next = {15'h0000, armed_reg, link.statusword};
        motion_pkg::REG_OBJ_RDATA: prdata_next = rdata_reg;
        motion_pkg::REG_IRQ_STATUS: prdata_next = {27'h0, ist_reg};
        motion_pkg::REG_IRQ_MASK: prdata_next = {27'h0, imask_reg};
        motion_pkg::REG_EMCY_CODE: prdata_next = {16'h0000, ecode_reg};
        motion_pkg::REG_EMCY_DATA: prdata_next = edata_reg;
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_reg <= 24'h0;
      wdata_reg <= 32'h0;
      rdata_reg <= 32'h0;
      prdata_reg <= 32'h0;
      edata_reg <= 32'h0;
      ecode_reg <= 16'h0000;
      sw_prev_reg <= 16'h0000;
      ist_reg <= '0;
      imask_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      sync_reg <= 1'b0;
      sync_pend_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      prdata_reg <= prdata_next;
      edata_reg <= edata_next;
      ecode_reg <= ecode_next;
      sw_prev_reg <= sw_prev_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      sync_reg <= sync_next;
      sync_pend_reg <= sync_pend_next;
      armed_reg <= armed_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign irq = |(ist_reg & imask_reg);
  assign link.obj_wr = wr_reg;
  assign link.obj_rd = rd_reg;
  assign link.obj_index = sel_reg[15:0];
  assign link.obj_sub = sel_reg[23:16];
  assign link.obj_wdata = wdata_reg;
  assign link.sync = sync_reg;
endmodule : motion_master

// [tb/motion_props.sv]
// Checker on the link between the master and drive ends.
// Instantiated by the bench beside the link interface.
`timescale 1ns/10ps
module motion_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic sync,
  input wire logic obj_rvalid,
  input wire logic [31:0] obj_rdata,
  input wire logic [15:0] statusword,
  input wire logic emcy_valid,
  input wire logic [15:0] emcy_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_RVALID: assert property (obj_rd |=> obj_rvalid) else $error("read unanswered");
  AST_COUNT: assert property (obj_rd && obj_index == 16'h60c1 && obj_sub == 8'h00
    |=> obj_rdata == 32'h0000_0003) else $error("bad entry count");
  AST_SUBMODE: assert property (obj_rd && obj_index == 16'h60c0
    |=> obj_rdata[15:0] inside {16'h0000, 16'hffff, 16'hfffe}) else $error("bad submode");
  AST_EMCY: assert property (emcy_valid |-> emcy_code == 16'hff11) else $error("bad code");
  AST_EMCY_ONCE: assert property (emcy_valid |=> !emcy_valid) else $error("emcy repeat");
  AST_BITS: assert property ((statusword & 16'h9bff) == 16'h0000) else $error("stray bit");
  AST_FERR_BIT: assert property (!(statusword[13] && statusword[14])) else $error("both");
  AST_SYNC: assert property (sync |=> !sync) else $error("sync too long");
endmodule : motion_props

// [tb/interp_position_and_window_monitor_tb.sv]
// Bench joining master and drive ends over the link interface.
// Software side is driven over APB; positions are driven directly.
`timescale 1ns/10ps
module interp_position_and_window_monitor_tb;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, apos = 32'h0, tpos = 32'd1000, loop_target, ffw_v;
  logic pready, pslverr, irq, err, fre = 1'b0, ffw = 1'b1, stopped = 1'b0;
  logic [1:0] frc = 2'h0, stop_code;
  logic [2:0] pmap = 3'h1;
  logic [31:0] vref;
  logic [15:0] imode;
  logic position_loop_on, native_units, stop_req, motor_disable;
  int n_errors = 0, comparisons = 0;
  motion_link_if u_link (.ref_clk(ref_clk));
  motion_master i_motion_master (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(u_link.master));
  motion_drive i_motion_drive (.ref_clk(ref_clk), .resetn(resetn), .link(u_link.drive),
    .actual_pos(apos), .target_pos(tpos), .pos_window(32'd5), .pos_window_cycles(32'd10),
    .ferr_window(32'd50), .ferr_timeout_cycles(32'd6), .following_fault_reaction_enable(fre),
    .fault_reaction_code(frc), .emergency_user_data_pair(32'h1234_5678),
    .ffw_from_position_enable(ffw), .pdo_map(pmap), .motor_stopped(stopped),
    .loop_target(loop_target), .velocity_ref(vref), .velocity_ffw(ffw_v),
    .position_loop_on(position_loop_on), .native_units(native_units), .interp_mode(imode),
    .stop_req(stop_req), .stop_code(stop_code), .motor_disable(motor_disable));
  motion_props i_motion_props (.ref_clk(ref_clk), .resetn(resetn), .obj_rd(u_link.obj_rd),
    .obj_index(u_link.obj_index), .obj_sub(u_link.obj_sub), .sync(u_link.sync),
    .obj_rvalid(u_link.obj_rvalid), .obj_rdata(u_link.obj_rdata),
    .statusword(u_link.statusword), .emcy_valid(u_link.emcy_valid),
    .emcy_code(u_link.emcy_code));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
    @(posedge ref_clk);
  endtask : apb
  // Selects the object, loads data, then issues the command bits
  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
    input logic [31:0] c);
    apb(1'b1, 8'h00, {8'h00, s, i});
    apb(1'b1, 8'h04, d);
    apb(1'b1, 8'h08, c);
    repeat (4) @(posedge ref_clk);
  endtask : obj
  task automatic t_record;
    apb(1'b1, 8'h18, 32'h10);
    obj(16'h60c1, 8'h00, 32'h0, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk("entry count", 32'h3, rd);
    chk("irq", 1, irq);
    apb(1'b0, 8'h14, 32'h0);
    chk("irq cleared", 0, irq);
    obj(16'h60c1, 8'h01, 32'h0, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("refused", 32'h8, rd & 32'h8);
    obj(16'h60c0, 8'h00, 32'h5, 32'h1);
    obj(16'h60c0, 8'h00, 32'h0, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk("reserved submode", 32'h0, {16'h0, rd[15:0]});
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    $display("record test done");
  endtask : t_record
  task automatic t_reached;
    apos <= 32'd1003;
    repeat (5) @(posedge ref_clk);
    chk("early reached", 0, u_link.statusword[10]);
    repeat (12) @(posedge ref_clk);
    chk("reached", 1, u_link.statusword[10]);
    chk("follow bit13", 1, u_link.statusword[13]);
    apos <= 32'd1010;
    repeat (3) @(posedge ref_clk);
    chk("left window", 0, u_link.statusword[10]);
    apos <= 32'd1003;
    repeat (5) @(posedge ref_clk);
    chk("dwell restart", 0, u_link.statusword[10]);
    $display("reached test done");
  endtask : t_reached
  task automatic t_interp;
    obj(16'h6060, 8'h00, 32'hca, 32'h1);
    chk("native", 1, native_units);
    obj(16'h1006, 8'h00, 32'd5000, 32'h1);
    obj(16'h60c1, 8'h01, 32'd1003, 32'h3);
    chk("linear held", 32'h0, loop_target);
    obj(16'h60c1, 8'h01, 32'd1003, 32'h2);
    chk("linear", 32'd1003, loop_target);
    obj(16'h60c0, 8'h00, 32'hfffe, 32'h1);
    chk("submode", 32'hfffe, {16'h0, imode});
    obj(16'h60c1, 8'h01, 32'd1010, 32'h3);
    obj(16'h60c1, 8'h01, 32'd1010, 32'h2);
    chk("cubic held", 32'd1003, loop_target);
    obj(16'h60c1, 8'h01, 32'd1010, 32'h2);
    chk("cubic", 32'd1010, loop_target);
    obj(16'h1006, 8'h00, 32'd1000, 32'h1);
    obj(16'h60c1, 8'h01, 32'd1003, 32'h3);
    chk("short", 32'd1003, loop_target);
    chk("feedforward", 32'hffff_fff9, ffw_v);
    pmap <= 3'h2;
    obj(16'h60c1, 8'h02, 32'd77, 32'h3);
    chk("velocity only", 0, position_loop_on);
    chk("velocity ref", 32'd77, vref);
    pmap <= 3'h5;
    ffw <= 1'b0;
    obj(16'h60c1, 8'h03, 32'd55, 32'h3);
    chk("rpm feedforward", 32'd55, ffw_v);
    pmap <= 3'h1;
    $display("interp test done");
  endtask : t_interp
  task automatic t_fault;
    apb(1'b1, 8'h18, 32'h1);
    apos <= 32'd1200;
    fre <= 1'b1;
    frc <= 2'h2;
    repeat (12) @(posedge ref_clk);
    chk("bit14", 32'h2, {30'h0, u_link.statusword[14:13]});
    chk("stop", 32'h6, {29'h0, stop_req, stop_code});
    stopped <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("disabled", 32'h3, {30'h0, motor_disable, irq});
    apb(1'b0, 8'h1c, 32'h0);
    chk("emcy code", 32'hff11, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("emcy data", 32'h1234_5678, rd);
    $display("fault test done");
  endtask : t_fault
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_record();
    t_reached();
    t_interp();
    t_fault();
    summarize();
  end
endmodule : interp_position_and_window_monitor_tb
